// ===== lsim_cfg.svh
`ifndef LSIM_CFG_SVH
`define LSIM_CFG_SVH

// ==========================================================
// register offsets (serial register pointer values)
`define LSIM_ADDR_TOP_FLAGS_ONE 8'h1A
`define LSIM_ADDR_TOP_FLAGS_TWO 8'h1B
`define LSIM_ADDR_LINREG_FLAGS 8'h1C
`define LSIM_ADDR_TOP_STATUS 8'h1D
`define LSIM_ADDR_LINREG_STATUS 8'h1F
`define LSIM_ADDR_MASK_ONE 8'h20
`define LSIM_ADDR_MASK_TWO 8'h21

// ==========================================================
// linreg_raw_status field positions
`define LSIM_BIT_B_ENABLED 7
`define LSIM_BIT_B_VOLT_INVALID 6
`define LSIM_BIT_B_CURR_LIMITED 4
`define LSIM_BIT_A_ENABLED 3
`define LSIM_BIT_A_VOLT_INVALID 2
`define LSIM_BIT_A_CURR_LIMITED 0

// ==========================================================
// top event positions, shared by mask one, flags one, top status (top status has no load meas bit)
`define LSIM_BIT_POWER_OK 7
`define LSIM_BIT_EXT_CLOCK 4
`define LSIM_BIT_THERMAL_WARN 2
`define LSIM_BIT_LOAD_MEAS 0
// mask two and flags two
`define LSIM_BIT_REG_RESET 0

// ==========================================================
// reset values
`define LSIM_RST_MASK_ONE 8'h90
`define LSIM_RST_MASK_TWO 8'h01
`define LSIM_RST_FLAGS 8'h00
// implemented bits of the linreg flag register (7 and 3 reserved)
`define LSIM_LINREG_FLAG_BITS 8'h77
// implemented bits of flags one
`define LSIM_TOP_FLAG_BITS 8'h95

`endif

// ===== lsim_host.sv
`timescale 1ns/1ps

// ==========================================================
// host model: serial bus master, open drain on data
module lsim_host (
    input wire logic sys_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // bus idle at time zero, data released to pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // quarter bit is four cycles; half periods stay at eight
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one bit out, line sampled mid high phase
    task automatic put_bit(input logic b, output logic r);
        sda_low <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(4);
        r = sda;
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask

    // also serves as repeated start from clock low
    task automatic start_cond();
        sda_low <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask

    task automatic stop_cond();
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(8);
    endtask

    // msb first, then the ack slot with data released
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(d[i], r);
        put_bit(1'b1, r);
        ack = ~r;
    endtask

    // one or two bytes, pointer auto-increments in between
    task automatic write_regs(input logic [6:0] a, input logic [7:0] p,
        input logic [7:0] d0, input logic [7:0] d1, input int n,
        output logic ok);
        logic k0, k1, k2, k3;
        start_cond();
        put_byte({a, 1'b0}, k0);
        put_byte(p, k1);
        put_byte(d0, k2);
        k3 = 1'b1;
        if (n > 1) put_byte(d1, k3);
        stop_cond();
        ok = k0 & k1 & k2 & k3;
    endtask

    // pointer write, repeated start, one byte, master nack
    task automatic read_reg(input logic [6:0] a, input logic [7:0] p,
        output logic [7:0] d, output logic ok);
        logic k0, k1, k2, r;
        start_cond();
        put_byte({a, 1'b0}, k0);
        put_byte(p, k1);
        start_cond();
        put_byte({a, 1'b1}, k2);
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(1'b1, r);
        stop_cond();
        ok = k0 & k1 & k2;
    endtask

    // two bytes from one pointer, master ack between them
    task automatic read_two(input logic [6:0] a, input logic [7:0] p,
        output logic [15:0] d, output logic ok);
        logic k0, k1, k2, r;
        start_cond();
        put_byte({a, 1'b0}, k0);
        put_byte(p, k1);
        start_cond();
        put_byte({a, 1'b1}, k2);
        for (int i = 15; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
            if (i == 8) put_bit(1'b0, r);
        end
        put_bit(1'b1, r);
        stop_cond();
        ok = k0 & k1 & k2;
    endtask
endmodule

// ===== lsim_monitor.sv
`timescale 1ns/1ps

// ==========================================================
// port checker for lsim_top, attached by bind
module lsim_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_pin,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic power_ok_pin,
    input wire logic ext_clock_event,
    input wire logic thermal_warn_event,
    input wire logic load_meas_ready_event,
    input wire logic register_reset_event,
    input wire logic [7:0] linreg_event,
    input wire logic irq_out
);
    // ======================================================
    // one clock domain
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // no event, steady pin, idle bus; eight cycles flush the synchroniser
    sequence inputs_quiet;
        (linreg_event == 8'h00 && !ext_clock_event && !thermal_warn_event
         && !load_meas_ready_event && !register_reset_event
         && $stable(power_ok_pin) && scl_pin && sda_in) [*8];
    endsequence
    // serial lines idle, so no write strobe can be pending
    sequence bus_idle;
        (scl_pin && sda_in) [*8];
    endsequence
    // clock high long enough for the synced copy to agree
    sequence scl_held;
        scl_pin [*6];
    endsequence

    // ======================================================
    // interrupt output
    linreg_irq_a: assert property (
        (linreg_event & 8'h77) != 8'h00 |-> ##2 irq_out)
        else $error("irq missing after regulator event");
    irq_hold_a: assert property (
        bus_idle ##0 irq_out |=> irq_out)
        else $error("irq dropped without a bus write");
    irq_quiet_a: assert property (
        inputs_quiet |=> $stable(irq_out))
        else $error("irq moved while inputs were quiet");
    // reset checks must run while reset is high
    reset_quiet_a: assert property (
        disable iff (1'b0) rst |-> !irq_out && !sda_oe)
        else $error("outputs active during reset");
    release_quiet_a: assert property (
        disable iff (1'b0) $fell(rst) |-> !irq_out ##1 !irq_out)
        else $error("irq active right after reset");

    // ======================================================
    // serial data driver
    oe_stable_a: assert property (
        scl_held |-> $stable(sda_oe))
        else $error("data drive changed with clock high");
    oe_change_a: assert property (
        $changed(sda_oe) |-> !scl_pin)
        else $error("data drive changed outside clock low");
    drive_low_a: assert property (
        sda_out == 1'b0)
        else $error("data output not open drain");
endmodule

// ===== lsim_pkg.sv
package lsim_pkg;

    // ======================================================
    // serial slave states, one-hot
    typedef enum logic [8:0] {
        LSIM_IDLE      = 9'b0_0000_0001,
        LSIM_ADDR      = 9'b0_0000_0010,
        LSIM_ADDR_ACK  = 9'b0_0000_0100,
        LSIM_REG       = 9'b0_0000_1000,
        LSIM_REG_ACK   = 9'b0_0001_0000,
        LSIM_WDATA     = 9'b0_0010_0000,
        LSIM_WDATA_ACK = 9'b0_0100_0000,
        LSIM_RDATA     = 9'b0_1000_0000,
        LSIM_RDATA_ACK = 9'b1_0000_0000
    } lsim_i2c_state_e;

endpackage

// ===== lsim_sync3.sv
`timescale 1ns/1ps

// ==========================================================
// three-stage input synchroniser with agreement filter
module lsim_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // stage one is read only by stage two
    logic [W-1:0] stage_one;
    logic [W-1:0] stage_two;
    logic [W-1:0] stage_three;

    // shift chain
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage_one <= RST_VAL;
            stage_two <= RST_VAL;
            stage_three <= RST_VAL;
        end else begin
            stage_one <= async_in;
            stage_two <= stage_one;
            stage_three <= stage_two;
        end
    end

    // a bit moves only when stages two and three agree
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_out <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage_two[i] == stage_three[i]) begin
                    sync_out[i] <= stage_three[i];
                end
            end
        end
    end
endmodule

// ===== lsim_tb.sv
`timescale 1ns/1ps

// compare, count, report at once
`define CHECK(got, want) begin \
    total_checks++; \
    if ((got) !== (want)) begin \
        fails++; \
        $display("[FAIL] t=%0t got=%h want=%h", $time, got, want); \
    end \
end

// ==========================================================
// testbench top
module tb;
    localparam logic [6:0] DEV = 7'h60; // arbitrary bus address
    localparam int POS [4] = '{0, 2, 4, 7}; // mask bit per event kind
    logic sys_clk, rst, scl, sda_low, sda_oe, sda_out, sda_wire, irq_out;
    logic power_ok_pin, clk_bad, therm, otp_rr, ok;
    logic [7:0] stat_in, lin_ev, otp_one, b;
    logic [15:0] rd_pair; // two-byte read result
    logic [4:0] ev; // meas, thermal, ext clock, unused, reg reset
    int fails, total_checks;

    // open drain data: either party pulls low, else pull-up
    assign sda_wire = (sda_low || sda_oe) ? 1'b0 : 1'b1;

    always #4 sys_clk = ~sys_clk;

    lsim_host host (.sys_clk(sys_clk), .sda(sda_wire), .scl(scl),
        .sda_low(sda_low));

    lsim_top #(.DEVICE_ADDR(DEV)) u_lsim_top (.sys_clk(sys_clk), .rst(rst),
        .scl_pin(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .linreg_a_enabled(stat_in[3]),
        .linreg_b_enabled(stat_in[7]),
        .linreg_a_voltage_invalid(stat_in[2]),
        .linreg_b_voltage_invalid(stat_in[6]),
        .linreg_a_current_limited(stat_in[0]),
        .linreg_b_current_limited(stat_in[4]),
        .power_ok_pin(power_ok_pin), .ext_clock_invalid(clk_bad),
        .thermal_warn_state(therm), .ext_clock_event(ev[2]),
        .thermal_warn_event(ev[1]), .load_meas_ready_event(ev[0]),
        .register_reset_event(ev[4]), .linreg_event(lin_ev),
        .otp_top_mask_one(otp_one), .otp_reset_reg_mask(otp_rr),
        .irq_out(irq_out));

    // ======================================================
    // register access helpers
    task automatic chk_rd(input logic [7:0] p, input logic [7:0] want);
        logic [7:0] got;
        logic k;
        host.read_reg(DEV, p, got, k);
        `CHECK(k, 1'b1)
        `CHECK(got, want)
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic k;
        host.write_regs(DEV, p, d, 8'h00, 1, k);
        `CHECK(k, 1'b1)
    endtask

    // kind 3 toggles the power pin; others pulse one cycle
    task automatic pulse(input int k);
        @(posedge sys_clk);
        if (k == 3) power_ok_pin <= ~power_ok_pin;
        else ev[k] <= 1'b1;
        @(posedge sys_clk);
        ev <= 5'h00;
        repeat (10) @(posedge sys_clk);
    endtask

    // reset held eight cycles, then synchroniser settling time
    task automatic do_reset();
        rst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // watchdog: full run is about thirty thousand cycles
    initial begin
        repeat (90000) @(posedge sys_clk);
        fails++;
        final_report();
    end

    // ======================================================
    // main sequence
    initial begin
        sys_clk = 1'b0;
        // low first, so do_reset gives the flops a real rising edge
        rst = 1'b0;
        power_ok_pin = 1'b0;
        clk_bad = 1'b0;
        therm = 1'b0;
        stat_in = 8'h00;
        lin_ev = 8'h00;
        ev = 5'h00;
        otp_one = 8'h90; // documented mask defaults
        otp_rr = 1'b1;
        fails = 0;
        total_checks = 0;
        do_reset();
        chk_rd(8'h20, 8'h90);
        chk_rd(8'h21, 8'h01);
        // walking one, reserved bits 5 and 1 must read zero
        for (int i = 0; i < 8; i++) begin
            stat_in <= 8'h01 << i;
            chk_rd(8'h1F, (8'h01 << i) & 8'hDD);
        end
        stat_in <= 8'hDD;
        wr(8'h1F, 8'h00);
        chk_rd(8'h1F, 8'hDD);
        chk_rd(8'h30, 8'h00);
        // foreign address must be ignored
        host.write_regs(DEV ^ 7'h01, 8'h20, 8'h00, 8'h00, 1, ok);
        `CHECK(ok, 1'b0)
        chk_rd(8'h20, 8'h90);
        chk_rd(8'h1D, 8'h00);
        // each top event: masked, then unmasked and cleared
        clk_bad <= 1'b1;
        therm <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            b = 8'h01 << POS[k];
            wr(8'h20, 8'hFF);
            pulse(k);
            `CHECK(irq_out, 1'b0)
            chk_rd(8'h1A, 8'h00);
            chk_rd(8'h1D, {power_ok_pin, 7'h14});
            wr(8'h20, ~b);
            pulse(k);
            `CHECK(irq_out, 1'b1)
            chk_rd(8'h1A, b);
            wr(8'h1A, b);
            `CHECK(irq_out, 1'b0)
        end
        // register reset event, default masked, then unmasked
        pulse(4);
        `CHECK(irq_out, 1'b0)
        host.write_regs(DEV, 8'h20, 8'h90, 8'h00, 2, ok);
        `CHECK(ok, 1'b1)
        chk_rd(8'h21, 8'h00);
        host.read_two(DEV, 8'h20, rd_pair, ok);
        `CHECK({ok, rd_pair}, {1'b1, 16'h9000})
        pulse(4);
        chk_rd(8'h1B, 8'h01);
        `CHECK(irq_out, 1'b1)
        wr(8'h1B, 8'h01);
        // second reset reloads masks from otp
        otp_one <= 8'h12;
        do_reset();
        chk_rd(8'h21, 8'h01);
        chk_rd(8'h20, 8'h12);
        // regulator flags: latch, write one clears, zero keeps
        lin_ev <= 8'hFF;
        @(posedge sys_clk);
        lin_ev <= 8'h00;
        repeat (4) @(posedge sys_clk);
        `CHECK(irq_out, 1'b1)
        chk_rd(8'h1C, 8'h77);
        wr(8'h1C, 8'h05);
        chk_rd(8'h1C, 8'h72);
        wr(8'h1C, 8'h00);
        chk_rd(8'h1C, 8'h72);
        wr(8'h1C, 8'h72);
        `CHECK(irq_out, 1'b0)
        final_report();
    end
endmodule

bind lsim_top lsim_monitor u_mon (.sys_clk, .rst, .scl_pin, .sda_in,
    .sda_out, .sda_oe, .power_ok_pin, .ext_clock_event, .thermal_warn_event,
    .load_meas_ready_event, .register_reset_event, .linreg_event, .irq_out);

// ===== lsim_top.sv
`timescale 1ns/1ps
`include "lsim_cfg.svh"

module lsim_top
    import lsim_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = 7'h60 // arbitrary default
) (
    input wire logic sys_clk,
    input wire logic rst,
    // serial bus, open drain data
    input wire logic scl_pin,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // regulator raw state, same clock
    input wire logic linreg_a_enabled,
    input wire logic linreg_b_enabled,
    input wire logic linreg_a_voltage_invalid,
    input wire logic linreg_b_voltage_invalid,
    input wire logic linreg_a_current_limited,
    input wire logic linreg_b_current_limited,
    // top raw state
    input wire logic power_ok_pin,
    input wire logic ext_clock_invalid,
    input wire logic thermal_warn_state,
    // one-cycle event pulses, same clock
    input wire logic ext_clock_event,
    input wire logic thermal_warn_event,
    input wire logic load_meas_ready_event,
    input wire logic register_reset_event,
    input wire logic [7:0] linreg_event,
    // one-time-programmable mask defaults
    input wire logic [7:0] otp_top_mask_one,
    input wire logic otp_reset_reg_mask,
    // interrupt, active high
    output logic irq_out
);

    // ======================================================
    // pin synchronisers
    logic [1:0] bus_sync; // {scl, sda}
    logic power_ok_pin_state; // filtered pin level
    logic scl_s;
    logic sda_s;

    lsim_sync3 #(.W(2), .RST_VAL(2'b11)) u_bus_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({scl_pin, sda_in}),
        .sync_out(bus_sync)
    );

    lsim_sync3 #(.W(1), .RST_VAL(1'b0)) u_pok_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(power_ok_pin),
        .sync_out(power_ok_pin_state)
    );

    assign scl_s = bus_sync[1];
    assign sda_s = bus_sync[0];

    // ======================================================
    // bus edge detection
    logic scl_d; // previous filtered clock
    logic sda_d; // previous filtered data
    logic pok_d; // previous pin state
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic power_ok_event; // any change of the power-good pin

    // history flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            pok_d <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            pok_d <= power_ok_pin_state;
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
    assign power_ok_event = power_ok_pin_state ^ pok_d;

    // ======================================================
    // registers
    logic [7:0] top_event_mask_one;
    logic [7:0] top_event_mask_two;
    logic [7:0] top_irq_flags_one;
    logic [7:0] top_irq_flags_two;
    logic [7:0] linreg_irq_flags;
    logic otp_pending; // first cycle after reset release
    logic wr_stb; // one-cycle register write pulse
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] linreg_raw_status;
    logic [7:0] top_raw_status;
    logic [7:0] rd_data;
    logic [7:0] reg_ptr; // auto-incrementing pointer

    // raw status, never touched by masks
    always_comb begin
        linreg_raw_status = 8'h00;
        linreg_raw_status[`LSIM_BIT_B_ENABLED] = linreg_b_enabled;
        linreg_raw_status[`LSIM_BIT_A_ENABLED] = linreg_a_enabled;
        linreg_raw_status[`LSIM_BIT_B_VOLT_INVALID] =
            linreg_b_voltage_invalid;
        linreg_raw_status[`LSIM_BIT_A_VOLT_INVALID] =
            linreg_a_voltage_invalid;
        linreg_raw_status[`LSIM_BIT_B_CURR_LIMITED] =
            linreg_b_current_limited;
        linreg_raw_status[`LSIM_BIT_A_CURR_LIMITED] =
            linreg_a_current_limited;
        top_raw_status = 8'h00;
        top_raw_status[`LSIM_BIT_POWER_OK] = power_ok_pin_state;
        top_raw_status[`LSIM_BIT_EXT_CLOCK] = ext_clock_invalid;
        top_raw_status[`LSIM_BIT_THERMAL_WARN] = thermal_warn_state;
    end

    // read mux, unmapped pointers read zero
    always_comb begin
        unique case (reg_ptr)
            `LSIM_ADDR_LINREG_STATUS: rd_data = linreg_raw_status;
            `LSIM_ADDR_TOP_STATUS: rd_data = top_raw_status;
            `LSIM_ADDR_MASK_ONE: rd_data = top_event_mask_one;
            `LSIM_ADDR_MASK_TWO: rd_data = top_event_mask_two;
            `LSIM_ADDR_TOP_FLAGS_ONE: rd_data = top_irq_flags_one;
            `LSIM_ADDR_TOP_FLAGS_TWO: rd_data = top_irq_flags_two;
            `LSIM_ADDR_LINREG_FLAGS: rd_data = linreg_irq_flags;
            default: rd_data = 8'h00;
        endcase
    end

    // masks; otp values replace the constants one cycle after release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            top_event_mask_one <= `LSIM_RST_MASK_ONE;
            top_event_mask_two <= `LSIM_RST_MASK_TWO;
            otp_pending <= 1'b1;
        end else if (otp_pending) begin
            otp_pending <= 1'b0;
            top_event_mask_one <= otp_top_mask_one;
            // a bus write never survives a reset
            top_event_mask_two <= {7'h00, otp_reset_reg_mask};
        end else if (wr_stb) begin
            if (wr_addr == `LSIM_ADDR_MASK_ONE) begin
                top_event_mask_one <= wr_data;
            end
            if (wr_addr == `LSIM_ADDR_MASK_TWO) begin
                top_event_mask_two <= wr_data;
            end
        end
    end

    // top flags; a set in the clearing cycle wins
    logic [7:0] top_set_one;
    logic [7:0] top_clr_one;
    logic top_set_two;
    logic top_clr_two;
    logic [7:0] linreg_clr;

    always_comb begin
        top_set_one = 8'h00;
        top_set_one[`LSIM_BIT_POWER_OK] = power_ok_event &
            ~top_event_mask_one[`LSIM_BIT_POWER_OK];
        top_set_one[`LSIM_BIT_EXT_CLOCK] = ext_clock_event &
            ~top_event_mask_one[`LSIM_BIT_EXT_CLOCK];
        top_set_one[`LSIM_BIT_THERMAL_WARN] = thermal_warn_event &
            ~top_event_mask_one[`LSIM_BIT_THERMAL_WARN];
        top_set_one[`LSIM_BIT_LOAD_MEAS] = load_meas_ready_event &
            ~top_event_mask_one[`LSIM_BIT_LOAD_MEAS];
        top_set_two = register_reset_event &
            ~top_event_mask_two[`LSIM_BIT_REG_RESET];
        top_clr_one = (wr_stb && wr_addr == `LSIM_ADDR_TOP_FLAGS_ONE) ?
            wr_data : 8'h00;
        top_clr_two = wr_stb && wr_addr == `LSIM_ADDR_TOP_FLAGS_TWO &&
            wr_data[`LSIM_BIT_REG_RESET];
        linreg_clr = (wr_stb && wr_addr == `LSIM_ADDR_LINREG_FLAGS) ?
            wr_data : 8'h00;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            top_irq_flags_one <= `LSIM_RST_FLAGS;
            top_irq_flags_two <= `LSIM_RST_FLAGS;
        end else begin
            top_irq_flags_one <= ((top_irq_flags_one & ~top_clr_one) |
                top_set_one) & `LSIM_TOP_FLAG_BITS;
            top_irq_flags_two[`LSIM_BIT_REG_RESET] <= top_set_two |
                (top_irq_flags_two[`LSIM_BIT_REG_RESET] & ~top_clr_two);
        end
    end

    // regulator flags, write one clears, zero leaves
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            linreg_irq_flags <= `LSIM_RST_FLAGS;
        end else begin
            linreg_irq_flags <= ((linreg_irq_flags & ~linreg_clr) |
                linreg_event) & `LSIM_LINREG_FLAG_BITS;
        end
    end

    // interrupt; masking a standing flag also hides it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= (|(top_irq_flags_one & ~top_event_mask_one)) |
                (top_irq_flags_two[`LSIM_BIT_REG_RESET] &
                ~top_event_mask_two[`LSIM_BIT_REG_RESET]) |
                (|linreg_irq_flags);
        end
    end

    // ======================================================
    // serial slave
    lsim_i2c_state_e state;
    logic [2:0] bit_cnt; // bits moved in this byte
    logic [7:0] shift; // receive or transmit byte
    logic byte_done; // eighth bit sampled
    logic rw_read; // direction of this access
    logic master_nack; // sampled ack bit from host

    // data pin is only ever pulled low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // protocol engine; start and stop override any state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= LSIM_IDLE;
            bit_cnt <= 3'd0;
            shift <= 8'h00;
            byte_done <= 1'b0;
            rw_read <= 1'b0;
            master_nack <= 1'b0;
            reg_ptr <= 8'h00;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (bus_start) begin
                state <= LSIM_ADDR;
                bit_cnt <= 3'd0;
                byte_done <= 1'b0;
                sda_oe <= 1'b0;
            end else if (bus_stop) begin
                state <= LSIM_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                // sample on rising clock
                if (state == LSIM_ADDR || state == LSIM_REG ||
                    state == LSIM_WDATA) begin
                    shift <= {shift[6:0], sda_s};
                    bit_cnt <= 3'(bit_cnt + 3'd1);
                    byte_done <= (bit_cnt == 3'd7);
                end else if (state == LSIM_RDATA_ACK) begin
                    master_nack <= sda_s;
                end
            end else if (scl_fall) begin
                // drive on falling clock
                unique case (state)
                    LSIM_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    LSIM_ADDR: begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            if (shift[7:1] == DEVICE_ADDR) begin
                                rw_read <= shift[0];
                                sda_oe <= 1'b1;
                                state <= LSIM_ADDR_ACK;
                            end else begin
                                state <= LSIM_IDLE;
                            end
                        end
                    end
                    LSIM_ADDR_ACK: begin
                        bit_cnt <= 3'd0;
                        if (rw_read) begin
                            shift <= rd_data;
                            sda_oe <= ~rd_data[7];
                            state <= LSIM_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= LSIM_REG;
                        end
                    end
                    LSIM_REG: begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            reg_ptr <= shift;
                            sda_oe <= 1'b1;
                            state <= LSIM_REG_ACK;
                        end
                    end
                    LSIM_REG_ACK: begin
                        sda_oe <= 1'b0;
                        bit_cnt <= 3'd0;
                        state <= LSIM_WDATA;
                    end
                    LSIM_WDATA: begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            wr_stb <= 1'b1;
                            wr_addr <= reg_ptr;
                            wr_data <= shift;
                            sda_oe <= 1'b1;
                            state <= LSIM_WDATA_ACK;
                        end
                    end
                    LSIM_WDATA_ACK: begin
                        sda_oe <= 1'b0;
                        bit_cnt <= 3'd0;
                        reg_ptr <= 8'(reg_ptr + 8'd1);
                        state <= LSIM_WDATA;
                    end
                    LSIM_RDATA: begin
                        if (bit_cnt == 3'd7) begin
                            sda_oe <= 1'b0;
                            reg_ptr <= 8'(reg_ptr + 8'd1);
                            state <= LSIM_RDATA_ACK;
                        end else begin
                            shift <= {shift[6:0], 1'b0};
                            sda_oe <= ~shift[6];
                            bit_cnt <= 3'(bit_cnt + 3'd1);
                        end
                    end
                    LSIM_RDATA_ACK: begin
                        bit_cnt <= 3'd0;
                        if (master_nack) begin
                            sda_oe <= 1'b0;
                            state <= LSIM_IDLE;
                        end else begin
                            shift <= rd_data;
                            sda_oe <= ~rd_data[7];
                            state <= LSIM_RDATA;
                        end
                    end
                endcase
            end
        end
    end
endmodule
